//--- design/adc_ctl_pkg.sv
// Shared constants and types for the converter control word logic
package adc_ctl_pkg;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int CW_WIDTH = 12;
    localparam int POWER_SEL_HI_BIT = 11;
    localparam int POWER_SEL_LO_BIT = 10;
    localparam int CODING_BIT = 9;
    localparam int REF_SRC_BIT = 8;
    localparam int SPARE_ZERO_BIT = 7;
    localparam int CHANNEL_SEL_HI_BIT = 6;
    localparam int CHANNEL_SEL_LO_BIT = 5;
    localparam int INPUT_KIND_HI_BIT = 4;
    localparam int INPUT_KIND_LO_BIT = 3;
    localparam int SEQUENCING_CTL_LO_BIT = 2;
    localparam int SEQUENCING_CTL_HI_BIT = 1;
    localparam int RANGE_BIT = 0;

    // Word after reset: normal power, everything else at zero
    localparam logic [CW_WIDTH-1:0] CTL_RESET_WORD = 12'hc00;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_AUTO_STANDBY = 2'h0,
        PM_AUTO_SHUTDOWN = 2'h1,
        PM_FULL_SHUTDOWN = 2'h2,
        PM_NORMAL = 2'h3
    } power_mode_t;

    typedef enum logic [1:0] {
        KIND_SINGLE = 2'h0,
        KIND_PSEUDO = 2'h1,
        KIND_DIFF = 2'h2,
        KIND_UNUSED = 2'h3
    } input_kind_t;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'h0,
        SEQ_UNUSED = 2'h1,
        SEQ_HOLD = 2'h2,
        SEQ_CONT = 2'h3
    } seq_ctl_t;

    // Power state machine, one-hot
    typedef enum logic [3:0] {
        PS_RUN = 4'h1,
        PS_WAKE = 4'h2,
        PS_STANDBY = 4'h4,
        PS_SHUTDOWN = 4'h8
    } pwr_state_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 200;
    localparam int STANDBY_WAKE_NS = 1000;
    localparam int STANDBY_WAKE_CYC = (STANDBY_WAKE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAKE_W = 16;
    localparam logic [WAKE_W-1:0] WAKE_ONE = 16'h0001;

endpackage

//--- design/ctl_word_if.sv
// Carrier for the captured control word between capture and decoder
interface ctl_word_if;
    import adc_ctl_pkg::*;

    logic [CW_WIDTH-1:0] word;
    logic commit;

    modport capture (
        output word,
        output commit
    );

    modport decoder (
        input word,
        input commit
    );
endinterface

//--- design/word_capture.sv
// Parallel port write capture for the control word
module word_capture
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Host write port
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic [CW_WIDTH-1:0] data_in,
    // Captured word toward the decoder
    ctl_word_if.capture cw
);

    typedef struct packed {
        logic active;
        logic [CW_WIDTH-1:0] shadow;
    } cap_state_t;

    cap_state_t st_reg;
    cap_state_t st_next;
    logic strobe;

    // Write is live while both strobes are low
    assign strobe = !cs_n && !wr_n;

    // Latest bus value during the strobe wins
    always_comb begin
        st_next = st_reg;
        st_next.active = strobe;
        if (strobe) begin
            st_next.shadow = data_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '{active: 1'b0, shadow: CTL_RESET_WORD};
        end else begin
            st_reg <= st_next;
        end
    end

    // Commit on the strobe's trailing edge, so a half-settled bus is never used
    assign cw.commit = st_reg.active && !strobe;
    assign cw.word = st_reg.shadow;

endmodule

//--- design/input_router.sv
// Maps channel address and input kind onto positive and negative inputs
module input_router
    import adc_ctl_pkg::*;
(
    // Selection
    input wire logic [1:0] channel,
    input wire input_kind_t kind,
    // Multiplexer selects
    output logic [1:0] pos_sel,
    output logic [1:0] neg_sel,
    output logic neg_ground
);

    // Paired modes use the partner of the same pair; the unused kind
    // falls back to single ended so the negative input never floats
    always_comb begin
        pos_sel = channel;
        neg_sel = channel ^ 2'h1;
        neg_ground = 1'b1;
        case (kind)
            KIND_DIFF: begin
                neg_ground = 1'b0;
            end
            KIND_PSEUDO: begin
                neg_ground = 1'b0;
            end
            default: begin
                neg_sel = 2'h0;
                neg_ground = 1'b1;
            end
        endcase
    end

endmodule

//--- design/adc_control_word_decoder.sv
// Control word decoder with sequencer and power management for the converter
module adc_control_word_decoder
    import adc_ctl_pkg::*;
#(
    parameter int SHUTDOWN_WAKE_CYC = 400
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Host parallel write port
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic [CW_WIDTH-1:0] data_in,
    // Conversion engine handshake
    input wire logic conv_start,
    input wire logic conv_done,
    output logic conv_busy,
    output logic [1:0] conv_channel,
    // Settings of the conversion in progress
    output logic coding_binary,
    output logic ref_external,
    output logic range_double,
    output logic [1:0] pos_input_sel,
    output logic [1:0] neg_input_sel,
    output logic neg_to_ground,
    // Power control
    output logic [1:0] power_mode,
    output logic core_power_on,
    output logic ref_power_on,
    output logic power_ready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All decoder state outside the capture stage in one word; the settings fields are the copy
    // frozen at the start of the running conversion
    typedef struct packed {
        logic [CW_WIDTH-1:0] ctl_word;
        pwr_state_t pwr;
        logic [WAKE_W-1:0] wake_cnt;
        logic start_pending;
        logic busy;
        logic seq_running;
        logic [1:0] seq_next;
        logic [1:0] conv_ch;
        logic coding;
        logic ref_ext;
        logic range2x;
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        logic neg_gnd;
    } dec_state_t;

    localparam dec_state_t STATE_RESET = '{
        ctl_word: CTL_RESET_WORD,
        pwr: PS_RUN,
        wake_cnt: '0,
        start_pending: 1'b0,
        busy: 1'b0,
        seq_running: 1'b0,
        seq_next: 2'h0,
        conv_ch: 2'h0,
        coding: 1'b0,
        ref_ext: 1'b0,
        range2x: 1'b0,
        pos_sel: 2'h0,
        neg_sel: 2'h0,
        neg_gnd: 1'b1
    };

    // Wake times in clock cycles; the shutdown one is longer because the
    // reference has to settle as well
    localparam logic [WAKE_W-1:0] STANDBY_WAKE = WAKE_W'(STANDBY_WAKE_CYC);
    localparam logic [WAKE_W-1:0] SHUTDOWN_WAKE = WAKE_W'(SHUTDOWN_WAKE_CYC);

    dec_state_t st_reg;
    dec_state_t st_next;

    // ------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------
    // Capture stage holds the word until the strobe has ended
    ctl_word_if cw ();

    word_capture u_capture (
        .ref_clk(ref_clk),
        .reset(reset),
        .cs_n(cs_n),
        .wr_n(wr_n),
        .data_in(data_in),
        .cw(cw)
    );

    // ------------------------------------------------------------
    // Field decode of the stored word; the sequencing field also from the incoming word
    // ------------------------------------------------------------
    // Bit 7 is never decoded; a stray one from the host has no effect
    power_mode_t pm_field;
    input_kind_t kind_field;
    seq_ctl_t seq_field;
    seq_ctl_t new_seq_field;
    logic [1:0] addr_field;

    assign pm_field = power_mode_t'({st_reg.ctl_word[POWER_SEL_HI_BIT],
                                     st_reg.ctl_word[POWER_SEL_LO_BIT]});
    assign kind_field = input_kind_t'({st_reg.ctl_word[INPUT_KIND_HI_BIT],
                                       st_reg.ctl_word[INPUT_KIND_LO_BIT]});
    assign seq_field = seq_ctl_t'({st_reg.ctl_word[SEQUENCING_CTL_HI_BIT],
                                   st_reg.ctl_word[SEQUENCING_CTL_LO_BIT]});
    assign new_seq_field = seq_ctl_t'({cw.word[SEQUENCING_CTL_HI_BIT],
                                       cw.word[SEQUENCING_CTL_LO_BIT]});
    assign addr_field = {st_reg.ctl_word[CHANNEL_SEL_HI_BIT],
                         st_reg.ctl_word[CHANNEL_SEL_LO_BIT]};

    // ------------------------------------------------------------
    // Channel choice for a conversion starting now
    // ------------------------------------------------------------
    logic seq_step;
    logic [1:0] start_ch;
    logic [1:0] follow_ch;
    logic [1:0] route_pos;
    logic [1:0] route_neg;
    logic route_gnd;

    // Sequencer position lives in seq_next, the channel after the last one
    // Hold mode only steps while a sequence is already under way
    assign seq_step = (seq_field == SEQ_CONT) ||
                      ((seq_field == SEQ_HOLD) && st_reg.seq_running);
    assign start_ch = seq_step ? (st_reg.seq_running ? st_reg.seq_next : 2'h0)
                               : addr_field;
    // Wrap at the final channel; >= also covers a final channel lowered mid-sequence
    assign follow_ch = (start_ch >= addr_field) ? 2'h0 : start_ch + 2'h1;

    input_router u_router (
        .channel(start_ch),
        .kind(kind_field),
        .pos_sel(route_pos),
        .neg_sel(route_neg),
        .neg_ground(route_gnd)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic go;

    always_comb begin
        st_next = st_reg;
        go = 1'b0;

        // Control word update; stored word never drives any read path
        // A write landing on the same edge as a start is seen by the
        // conversion after it, never by that start
        if (cw.commit) begin
            st_next.ctl_word = cw.word;
            // Continuous mode restarts from channel 0, hold mode keeps going
            if (new_seq_field == SEQ_CONT) begin
                st_next.seq_running = 1'b0;
            end else if (new_seq_field != SEQ_HOLD) begin
                st_next.seq_running = 1'b0;
            end
        end

        // End of conversion
        if (conv_done && st_reg.busy) begin
            st_next.busy = 1'b0;
        end

        // Power state machine
        // Run: circuits up, starts accepted
        // Wake: counting down the power-up time; starts are remembered
        // Standby: core down, reference up; a start wakes it
        // Shutdown: everything down, the stored word is kept
        case (st_reg.pwr)
            PS_RUN: begin
                if (pm_field == PM_FULL_SHUTDOWN) begin
                    st_next.pwr = PS_SHUTDOWN;
                    st_next.busy = 1'b0;
                    st_next.start_pending = 1'b0;
                end else if (conv_done && st_reg.busy) begin
                    if (pm_field == PM_AUTO_SHUTDOWN) begin
                        st_next.pwr = PS_SHUTDOWN;
                    end else if (pm_field == PM_AUTO_STANDBY) begin
                        st_next.pwr = PS_STANDBY;
                    end
                end else if ((conv_start || st_reg.start_pending) && !st_reg.busy) begin
                    go = 1'b1;
                    st_next.start_pending = 1'b0;
                end
            end
            PS_WAKE: begin
                if (pm_field == PM_FULL_SHUTDOWN) begin
                    st_next.pwr = PS_SHUTDOWN;
                    st_next.start_pending = 1'b0;
                end else begin
                    if (conv_start) begin
                        st_next.start_pending = 1'b1;
                    end
                    if (st_reg.wake_cnt <= WAKE_ONE) begin
                        st_next.pwr = PS_RUN;
                        st_next.wake_cnt = '0;
                    end else begin
                        st_next.wake_cnt = st_reg.wake_cnt - WAKE_ONE;
                    end
                end
            end
            PS_STANDBY: begin
                // Reference stayed up, so the return is the short one
                if (pm_field == PM_FULL_SHUTDOWN) begin
                    st_next.pwr = PS_SHUTDOWN;
                end else if (conv_start || pm_field == PM_NORMAL) begin
                    st_next.pwr = PS_WAKE;
                    st_next.wake_cnt = STANDBY_WAKE;
                    st_next.start_pending = conv_start;
                end
            end
            PS_SHUTDOWN: begin
                // Full shutdown ignores starts; only a new power mode leaves it
                if (pm_field == PM_NORMAL) begin
                    st_next.pwr = PS_WAKE;
                    st_next.wake_cnt = SHUTDOWN_WAKE;
                end else if (conv_start && pm_field != PM_FULL_SHUTDOWN) begin
                    st_next.pwr = PS_WAKE;
                    st_next.wake_cnt = SHUTDOWN_WAKE;
                    st_next.start_pending = 1'b1;
                end
            end
            default: begin
                st_next.pwr = PS_RUN;
            end
        endcase

        // Conversion start: freeze the settings it runs with
        // so a write during the conversion cannot disturb the analog path
        if (go) begin
            st_next.busy = 1'b1;
            st_next.conv_ch = start_ch;
            st_next.seq_running = seq_step;
            st_next.seq_next = follow_ch;
            st_next.coding = st_reg.ctl_word[CODING_BIT];
            st_next.ref_ext = st_reg.ctl_word[REF_SRC_BIT];
            st_next.range2x = st_reg.ctl_word[RANGE_BIT];
            st_next.pos_sel = route_pos;
            st_next.neg_sel = route_neg;
            st_next.neg_gnd = route_gnd;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Settings stay frozen for the whole conversion; a write mid-conversion
    // waits for the next start
    assign conv_busy = st_reg.busy;
    assign conv_channel = st_reg.conv_ch;
    assign coding_binary = st_reg.coding;
    assign ref_external = st_reg.ref_ext;
    assign range_double = st_reg.range2x;
    assign pos_input_sel = st_reg.pos_sel;
    assign neg_input_sel = st_reg.neg_sel;
    assign neg_to_ground = st_reg.neg_gnd;

    // Power on and ready outputs follow the state, power_mode the stored word; reference only drops in shutdown
    // Power ready low means a start is held off or remembered
    assign power_mode = pm_field;
    assign core_power_on = (st_reg.pwr == PS_RUN) || (st_reg.pwr == PS_WAKE);
    assign ref_power_on = (st_reg.pwr != PS_SHUTDOWN);
    assign power_ready = (st_reg.pwr == PS_RUN);

endmodule

//--- test/adc_ctl_checker.sv
// Port-level assertions for the control word decoder
module adc_ctl_checker
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Watched ports
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conv_busy,
    input wire logic [1:0] conv_channel,
    input wire logic coding_binary,
    input wire logic range_double,
    input wire logic [1:0] pos_input_sel,
    input wire logic [1:0] neg_input_sel,
    input wire logic neg_to_ground,
    input wire logic [1:0] power_mode,
    input wire logic core_power_on,
    input wire logic ref_power_on,
    input wire logic power_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // -------------------------------------------
    // Assertions
    // -------------------------------------------
    reset_values_a: assert property ($fell(reset) |->
        power_mode == 2'h3 && power_ready && !conv_busy && neg_to_ground)
        else $error("state after reset wrong");
    // A start right after a shutdown write is dropped, so that case is left out
    start_taken_a: assert property (
        conv_start && power_ready && !conv_busy && power_mode != 2'h2 |=> conv_busy)
        else $error("start not taken");
    done_clears_a: assert property (conv_busy && conv_done |=> !conv_busy)
        else $error("busy outlived done");
    settings_frozen_a: assert property (conv_busy && $past(conv_busy) |->
        $stable(coding_binary) && $stable(range_double) && $stable(conv_channel))
        else $error("settings moved mid conversion");
    ground_route_a: assert property (neg_to_ground |-> neg_input_sel == 2'h0)
        else $error("grounded negative select not zero");
    pair_route_a: assert property (
        !neg_to_ground |-> neg_input_sel == (pos_input_sel ^ 2'h1))
        else $error("pair partner wrong");
    busy_channel_a: assert property (conv_busy |-> pos_input_sel == conv_channel)
        else $error("positive input differs from channel");
    full_down_a: assert property (power_mode == 2'h2 ##1 power_mode == 2'h2 |->
        !core_power_on && !ref_power_on && !power_ready)
        else $error("full shutdown left power on");
    auto_down_a: assert property (
        power_mode == 2'h1 && conv_busy && conv_done |=> !core_power_on && !ref_power_on)
        else $error("auto shutdown missed");
    auto_standby_a: assert property (
        power_mode == 2'h0 && conv_busy && conv_done |=> !core_power_on && ref_power_on)
        else $error("auto standby wrong");

    // Main scenarios reached
    cover property (conv_busy && conv_done && power_mode == 2'h0);
    cover property (conv_busy && !neg_to_ground);
    cover property (power_mode == 2'h2 && conv_start);
endmodule

//--- test/host_model.sv
// Host processor model writing the control word over the parallel port
module host_model
    import adc_ctl_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Parallel write port
    output logic cs_n,
    output logic wr_n,
    output logic [CW_WIDTH-1:0] data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        data_in = 12'h000;
    end

    // One strobe cycle, then release; released bus shows the inverse, not a stale word
    task automatic write(input logic [CW_WIDTH-1:0] w);
        cs_n = 1'b0;
        wr_n = 1'b0;
        data_in = w & 12'hf7f;
        @(posedge ref_clk);
        #1;
        cs_n = 1'b1;
        wr_n = 1'b1;
        data_in = ~data_in;
        @(posedge ref_clk);
        #1;
    endtask
endmodule

//--- test/test_adc_control_word_decoder.sv
// Self-checking bench for the control word decoder
module test_adc_control_word_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_ctl_pkg::*;

    logic ref_clk = 1'b0;
    logic reset;
    logic conv_start;
    logic conv_done;
    logic cs_n, wr_n;
    logic [CW_WIDTH-1:0] data_in;
    logic conv_busy, coding_binary, ref_external, range_double, neg_to_ground;
    logic core_power_on, ref_power_on, power_ready;
    logic [1:0] conv_channel, pos_input_sel, neg_input_sel, power_mode;
    int miscompares = 0;
    int check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    host_model host_model_inst (.ref_clk(ref_clk), .cs_n(cs_n), .wr_n(wr_n), .data_in(data_in));

    // Wake from shutdown shortened to keep the run brief
    adc_control_word_decoder #(.SHUTDOWN_WAKE_CYC(4)) adc_control_word_decoder_inst (
        .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .data_in(data_in),
        .conv_start(conv_start), .conv_done(conv_done), .conv_busy(conv_busy),
        .conv_channel(conv_channel), .coding_binary(coding_binary),
        .ref_external(ref_external), .range_double(range_double),
        .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
        .neg_to_ground(neg_to_ground), .power_mode(power_mode),
        .core_power_on(core_power_on), .ref_power_on(ref_power_on),
        .power_ready(power_ready));

    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Start pulse, then bounded wait for busy (covers wake delays)
    task automatic start_conv(output int n);
        conv_start = 1'b1;
        cyc(1);
        conv_start = 1'b0;
        n = 0;
        while (conv_busy !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chk(conv_busy, 1'b1);
    endtask

    task automatic end_conv();
        conv_done = 1'b1;
        cyc(1);
        conv_done = 1'b0;
        chk(conv_busy, 1'b0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_reset();
        chk(power_mode, 2'h3);
        chk({core_power_on, ref_power_on, power_ready}, 3'h7);
        chk({conv_busy, neg_to_ground}, 2'h1);
    endtask

    // Every input kind and channel; a write while busy must not leak in
    task automatic t_fields();
        logic [1:0] k;
        logic [11:0] w;
        int n;
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            w = {2'h3, k[0], k[1], 1'b0, k, k, 2'h0, k[0]};
            host_model_inst.write(w);
            start_conv(n);
            chk({coding_binary, ref_external, range_double}, {k[0], k[1], k[0]});
            chk(pos_input_sel, k);
            chk(conv_channel, k);
            chk(neg_to_ground, (k == 2'h0 || k == 2'h3));
            chk(neg_input_sel, (k == 2'h1 || k == 2'h2) ? (k ^ 2'h1) : 2'h0);
            host_model_inst.write(w ^ 12'h201);
            chk({coding_binary, range_double}, {k[0], k[0]});
            end_conv();
        end
    endtask

    // Continuous run to channel 2, hold across a write, then single channel
    task automatic t_seq();
        int n;
        host_model_inst.write(12'hc46);
        for (int i = 0; i < 4; i++) begin
            start_conv(n);
            chk(conv_channel, i % 3);
            end_conv();
        end
        host_model_inst.write(12'he42);
        start_conv(n);
        chk({conv_channel, coding_binary}, 3'h3);
        end_conv();
        for (int i = 0; i < 2; i++) begin
            host_model_inst.write(12'hc20);
            start_conv(n);
            chk(conv_channel, 2'h1);
            end_conv();
        end
    endtask

    task automatic t_power();
        int n;
        host_model_inst.write(12'h800);
        cyc(1); // Power state follows the stored word one edge later
        chk({power_mode, core_power_on, ref_power_on, power_ready}, 5'h10);
        conv_start = 1'b1;
        cyc(1);
        conv_start = 1'b0;
        cyc(2);
        chk(conv_busy, 1'b0);
        host_model_inst.write(12'hc00);
        cyc(10);
        chk(power_ready, 1'b1);
        host_model_inst.write(12'h400);
        start_conv(n);
        end_conv();
        chk({core_power_on, ref_power_on}, 2'h0);
        start_conv(n);
        chk(n >= 4, 1'b1);
        host_model_inst.write(12'h000);
        end_conv();
        chk({core_power_on, ref_power_on}, 2'h1);
        start_conv(n);
        chk(n > 195 && n < 210, 1'b1);
        end_conv();
        host_model_inst.write(12'hc00);
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end

    // Stimulus starts idle with reset held
    initial begin
        reset = 1'b1;
        conv_start = 1'b0;
        conv_done = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        cyc(1);
        t_reset();
        t_fields();
        t_seq();
        t_power();
        tally_and_finish();
    end
endmodule

bind adc_control_word_decoder adc_ctl_checker adc_ctl_checker_inst (
    .ref_clk(ref_clk), .reset(reset), .conv_start(conv_start), .conv_done(conv_done),
    .conv_busy(conv_busy), .conv_channel(conv_channel), .coding_binary(coding_binary),
    .range_double(range_double), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .neg_to_ground(neg_to_ground), .power_mode(power_mode),
    .core_power_on(core_power_on), .ref_power_on(ref_power_on), .power_ready(power_ready));
